/* File: low_leakage_wakeup_select.sv */
`timescale 1ns/1ns
// Overview of operation
// - Pin field picks off, rising, falling, any.
// - Select byte A holds pins 11 to 8.
// - Select byte B holds pins 15 to 12.
// - Module enable bit gates its module flag.
// - Enable bit n belongs to module n.
// - Selections clear only on full chip reset.
// - Wake flags clear only by writing one or on full chip reset.
module low_leakage_wakeup_select
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] wake_pins,
  input wire logic [7:0] module_wake_flags,
  output logic wake_req,
  output logic irq
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic run_rst_n;
  logic chip_sync_n;

  reset_sync u_run_rst
  (
    .clk(clk),
    .rst_in_n(rst_n),
    .rst_out_n(run_rst_n)
  );

  // The chip reset alone may wipe the selection, so it has its own copy.
  reset_sync u_chip_rst
  (
    .clk(clk),
    .rst_in_n(chip_rst_n),
    .rst_out_n(chip_sync_n)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] pin_wake_select_8_11;
    logic [7:0] pin_wake_select_12_15;
    logic [7:0] module_wake_enable;
    logic [7:0] pin_wake_flag;
    logic [7:0] module_flag;
  } kept_state_t;

  typedef struct packed
  {
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq;
    logic wake_req;
  } run_state_t;

  kept_state_t kept;
  kept_state_t next_kept;
  run_state_t run;
  run_state_t next_run;

  logic [7:0] pin_hit;
  logic access;
  logic done;
  logic wr;
  logic rd;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic [7:0] mod_hit;

  pin_wake_detect u_detect
  (
    .clk(clk),
    .rst_n(run_rst_n),
    .wake_pins(wake_pins),
    .pin_edge_sel_field({kept.pin_wake_select_12_15,
                         kept.pin_wake_select_8_11}),
    .pin_hit(pin_hit)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [9:0] i);
    logic m;
    m = 1'b0;
    if (i == wake_sel_pkg::IDX_SEL_8_11)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_SEL_12_15)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_MOD_EN)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_PIN_FLAG)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_MOD_FLAG)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_IRQ_STATUS)
      m = 1'b1;
    else if (i == wake_sel_pkg::IDX_IRQ_MASK)
      m = 1'b1;
    return m;
  endfunction

  assign idx = paddr[11:2];
  assign access = psel && penable;
  assign done = access && run.ready;
  assign wr = done && pwrite && pstrb[0] && is_mapped(idx);
  assign rd = done && !pwrite;
  assign wbyte = pwdata[7:0];
  assign mod_hit = module_wake_flags & kept.module_wake_enable;

  // ----------------------------------------------------------------
  // Retained registers and wake flags
  // ----------------------------------------------------------------
  always_comb
  begin
    next_kept = kept;
    if (wr && idx == wake_sel_pkg::IDX_SEL_8_11)
      next_kept.pin_wake_select_8_11 = wbyte;
    if (wr && idx == wake_sel_pkg::IDX_SEL_12_15)
      next_kept.pin_wake_select_12_15 = wbyte;
    if (wr && idx == wake_sel_pkg::IDX_MOD_EN)
      next_kept.module_wake_enable = wbyte;
    if (wr && idx == wake_sel_pkg::IDX_PIN_FLAG)
      next_kept.pin_wake_flag = kept.pin_wake_flag & ~wbyte;
    if (wr && idx == wake_sel_pkg::IDX_MOD_FLAG)
      next_kept.module_flag = kept.module_flag & ~wbyte;
    // A new detection in the clearing cycle must survive the clear.
    next_kept.pin_wake_flag = next_kept.pin_wake_flag | pin_hit;
    next_kept.module_flag = next_kept.module_flag | mod_hit;
  end

  always_ff @(posedge clk or negedge chip_sync_n)
  begin
    if (!chip_sync_n)
      kept <= '0;
    else
      kept <= next_kept;
  end

  // ----------------------------------------------------------------
  // Bus answer, interrupt and wake request
  // ----------------------------------------------------------------
  always_comb
  begin
    next_run = run;
    next_run.ready = access && !run.ready;
    if (access && !run.ready)
    begin
      next_run.slverr = !is_mapped(idx);
      next_run.rdata = wake_sel_pkg::DATA_ZERO;
      if (idx == wake_sel_pkg::IDX_SEL_8_11)
        next_run.rdata[7:0] = kept.pin_wake_select_8_11;
      else if (idx == wake_sel_pkg::IDX_SEL_12_15)
        next_run.rdata[7:0] = kept.pin_wake_select_12_15;
      else if (idx == wake_sel_pkg::IDX_MOD_EN)
        next_run.rdata[7:0] = kept.module_wake_enable;
      else if (idx == wake_sel_pkg::IDX_PIN_FLAG)
        next_run.rdata[7:0] = kept.pin_wake_flag;
      else if (idx == wake_sel_pkg::IDX_MOD_FLAG)
        next_run.rdata[7:0] = kept.module_flag;
      else if (idx == wake_sel_pkg::IDX_IRQ_STATUS)
        next_run.rdata[1:0] = run.irq_status;
      else if (idx == wake_sel_pkg::IDX_IRQ_MASK)
        next_run.rdata[1:0] = run.irq_mask;
    end
    else if (!access)
    begin
      next_run.slverr = 1'b0;
      next_run.rdata = wake_sel_pkg::DATA_ZERO;
    end
    if (rd && idx == wake_sel_pkg::IDX_IRQ_STATUS)
      next_run.irq_status = wake_sel_pkg::IRQ_RESET;
    if (wr && idx == wake_sel_pkg::IDX_IRQ_MASK)
      next_run.irq_mask = wbyte[1:0];
    if (pin_hit != wake_sel_pkg::REG_RESET)
      next_run.irq_status[wake_sel_pkg::IRQ_PIN_BIT] = 1'b1;
    if (mod_hit != wake_sel_pkg::REG_RESET)
      next_run.irq_status[wake_sel_pkg::IRQ_MOD_BIT] = 1'b1;
    next_run.irq = |(next_run.irq_status & next_run.irq_mask);
    next_run.wake_req = |(next_kept.pin_wake_flag
                          | next_kept.module_flag);
  end

  always_ff @(posedge clk or negedge run_rst_n)
  begin
    if (!run_rst_n)
      run <= '0;
    else
      run <= next_run;
  end

  assign prdata = run.rdata;
  assign pready = run.ready;
  assign pslverr = run.slverr;
  assign irq = run.irq;
  assign wake_req = run.wake_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_access;
    psel && penable && !pready;
  endsequence

  // The access phase is spelt out here: a named sequence may not stand
  // inside a boolean and.
  sequence s_write_sel_lo;
    (psel && penable && !pready) && pwrite && pstrb[0]
      && idx == wake_sel_pkg::IDX_SEL_8_11
      ##1 pready;
  endsequence

  sequence s_write_sel_hi;
    (psel && penable && !pready) && pwrite && pstrb[0]
      && idx == wake_sel_pkg::IDX_SEL_12_15
      ##1 pready;
  endsequence

  sequence s_write_en;
    (psel && penable && !pready) && pwrite && pstrb[0]
      && idx == wake_sel_pkg::IDX_MOD_EN
      ##1 pready;
  endsequence

  property p_sel_lo;
    @(posedge clk) disable iff (!run_rst_n || !chip_sync_n)
    s_write_sel_lo |=> kept.pin_wake_select_8_11 == $past(pwdata[7:0]);
  endproperty
  a_sel_lo: assert property (p_sel_lo)
    else $error("select byte for pins 8 to 11 not written");

  property p_sel_hi;
    @(posedge clk) disable iff (!run_rst_n || !chip_sync_n)
    s_write_sel_hi |=> kept.pin_wake_select_12_15 == $past(pwdata[7:0]);
  endproperty
  a_sel_hi: assert property (p_sel_hi)
    else $error("select byte for pins 12 to 15 not written");

  property p_en_write;
    @(posedge clk) disable iff (!run_rst_n || !chip_sync_n)
    s_write_en |=> kept.module_wake_enable == $past(pwdata[7:0]);
  endproperty
  a_en_write: assert property (p_en_write)
    else $error("module enable byte not written");

  property p_mod_gate;
    @(posedge clk) disable iff (!chip_sync_n)
    ((kept.module_flag & ~$past(kept.module_flag)
      & ~$past(mod_hit)) == wake_sel_pkg::REG_RESET);
  endproperty
  a_mod_gate: assert property (p_mod_gate)
    else $error("module flag set without an enabled source");

  property p_flag_hold;
    @(posedge clk) disable iff (!chip_sync_n)
    ((($past(kept.pin_wake_flag) & ~kept.pin_wake_flag) != 8'h00)
     || (($past(kept.module_flag) & ~kept.module_flag) != 8'h00))
    |-> $past(wr);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("wake flag dropped without a write");

  property p_keep_on_reset;
    @(posedge clk) disable iff (!chip_sync_n)
    !run_rst_n |=> $stable(kept.pin_wake_select_8_11)
                   && $stable(kept.module_wake_enable);
  endproperty
  a_keep_on_reset: assert property (p_keep_on_reset)
    else $error("selection lost on a non-chip reset");

  property p_wake;
    @(posedge clk) disable iff (!run_rst_n || !chip_sync_n)
    (pin_hit != 8'h00) |=> wake_req [*2];
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake request not raised after a pin hit");

  property p_answer;
    @(posedge clk) disable iff (!run_rst_n)
    s_access |=> pready ##1 !pready;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not a single cycle after access");

endmodule

/* File: low_leakage_wakeup_select_test.sv */
`timescale 1ns/1ns
`define CHK(g, e) \
  begin \
    n_tests++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("MISMATCH %0t got %h exp %h", $time, g, e); \
    end \
  end
module low_leakage_wakeup_select_test;
  localparam logic [11:0] A_S0 = 12'h008;
  localparam logic [11:0] A_S1 = 12'h00c;
  localparam logic [11:0] A_ME = 12'h010;
  localparam logic [11:0] A_PF = 12'h014;
  localparam logic [11:0] A_MF = 12'h018;
  localparam logic [11:0] A_ST = 12'h020;
  localparam logic [11:0] A_MK = 12'h024;
  logic clk = 1'b0;
  logic rst_n;
  logic chip_rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] wake_pins;
  logic [7:0] module_wake_flags;
  logic wake_req;
  logic irq;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  low_leakage_wakeup_select u_low_leakage_wakeup_select
  (
    .clk(clk), .rst_n(rst_n), .chip_rst_n(chip_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pins(wake_pins), .module_wake_flags(module_wake_flags),
    .wake_req(wake_req), .irq(irq)
  );

  wake_source_model u_wake_source_model
  (
    .clk(clk), .wake_pins(wake_pins),
    .module_wake_flags(module_wake_flags)
  );

  // ----------------------------------------------------------------
  // Bus access and closing
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  task automatic do_reset(input logic chip);
    @(posedge clk);
    rst_n <= 1'b0;
    chip_rst_n <= ~chip;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chip_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic close_out;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    // Driven at time zero so that both resets see a falling edge at once.
    rst_n <= 1'b0;
    chip_rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    pstrb <= 4'hf;
    do_reset(1'b1);
    rchk(A_S0, 32'h0);
    rchk(A_S1, 32'h0);
    rchk(A_ME, 32'h0);
    wr(A_S0, 32'h0000_00e4);
    rchk(A_S0, 32'h0000_00e4);
    wr(A_S1, 32'hffff_ff1b);
    rchk(A_S1, 32'h0000_001b);
    wr(A_ME, 32'h0000_00a5);
    rchk(A_ME, 32'h0000_00a5);
    pstrb <= 4'he;
    wr(A_ME, 32'h0000_0000);
    pstrb <= 4'hf;
    rchk(A_ME, 32'h0000_00a5);
    xfer(1'b0, 12'h01c, 32'h0);
    `CHK(err, 1'b1)
    // A bus-side reset alone must leave the selections in place.
    do_reset(1'b0);
    rchk(A_S0, 32'h0000_00e4);
    rchk(A_ME, 32'h0000_00a5);
    do_reset(1'b1);
    rchk(A_S1, 32'h0);
    rchk(A_ME, 32'h0);
    // Every mode on every pin, rising then falling.
    for (int p = 0; p < 8; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr(p < 4 ? A_S0 : A_S1, 32'(m) << (2 * (p % 4)));
        u_wake_source_model.set_pins(8'h01 << p);
        repeat (8) @(posedge clk);
        `CHK(wake_req, m[0])
        rchk(A_PF, 32'(m[0]) << p);
        wr(A_PF, 32'h0000_00ff);
        u_wake_source_model.set_pins(8'h00);
        repeat (8) @(posedge clk);
        rchk(A_PF, 32'(m[1]) << p);
        wr(A_PF, 32'h0000_00ff);
      end
    wr(A_S1, 32'h0);
    wr(A_S0, 32'h1);
    u_wake_source_model.set_pins(8'h01);
    repeat (8) @(posedge clk);
    wr(A_S0, 32'h0);
    rchk(A_PF, 32'h1);
    wr(A_PF, 32'h1);
    rchk(A_PF, 32'h0);
    `CHK(wake_req, 1'b0)
    u_wake_source_model.set_pins(8'h00);
    // The last pass enables nothing, so no flag may stick.
    for (int n = 0; n < 9; n++)
    begin
      wr(A_ME, 32'h1 << n);
      u_wake_source_model.pulse_flags(8'hff);
      repeat (3) @(posedge clk);
      `CHK(wake_req, n < 8)
      rchk(A_MF, (32'h1 << n) & 32'hff);
      wr(A_MF, 32'hff);
    end
    xfer(1'b0, A_ST, 32'h0);
    wr(A_MK, 32'h2);
    rchk(A_MK, 32'h2);
    wr(A_ME, 32'h1);
    u_wake_source_model.pulse_flags(8'h01);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b1)
    rchk(A_ST, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(A_S0, 32'h1);
    u_wake_source_model.set_pins(8'h01);
    repeat (8) @(posedge clk);
    `CHK(irq, 1'b0)
    rchk(A_ST, 32'h1);
    close_out();
  end
endmodule

/* File: pin_wake_detect.sv */
`timescale 1ns/1ns
module pin_wake_detect
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] wake_pins,
  input wire logic [15:0] pin_edge_sel_field,
  output logic [7:0] pin_hit
);

  typedef struct packed
  {
    logic [7:0] meta;
    logic [7:0] cur;
    logic [7:0] prev;
    logic [7:0] hit;
  } det_state_t;

  det_state_t st;
  det_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.meta = wake_pins;
    next_st.cur = st.meta;
    next_st.prev = st.cur;
    for (int i = 0; i < wake_sel_pkg::NUM_PINS; i++)
    begin
      next_st.hit[i] = wake_sel_pkg::edge_hit(
        pin_edge_sel_field[i*wake_sel_pkg::FIELD_W +: wake_sel_pkg::FIELD_W],
        st.prev[i], st.cur[i]);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pin_hit = st.hit;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_rise_hit;
    @(posedge clk) disable iff (!rst_n)
    (pin_edge_sel_field[1:0] == wake_sel_pkg::MODE_RISE && st.cur[0]
     && !st.prev[0]) |=> pin_hit[0];
  endproperty
  a_rise_hit: assert property (p_rise_hit)
    else $error("rising edge on pin 8 not detected");

  property p_off_quiet;
    @(posedge clk) disable iff (!rst_n)
    (pin_edge_sel_field[1:0] == wake_sel_pkg::MODE_OFF) |=> !pin_hit[0];
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("disabled pin 8 produced a hit");

endmodule

/* File: reset_sync.sv */
`timescale 1ns/1ns
module reset_sync
(
  input wire logic clk,
  input wire logic rst_in_n,
  output logic rst_out_n
);

  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // Assertion is immediate; release waits two edges to avoid metastability.
  always_comb
  begin
    next_st.stage1 = 1'b1;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clk or negedge rst_in_n)
  begin
    if (!rst_in_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign rst_out_n = st.stage2;

endmodule

/* File: wake_sel_pkg.sv */
package wake_sel_pkg;

  // ----------------------------------------------------------------
  // Register map: word index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int IDX_W = 10;
  localparam logic [9:0] IDX_SEL_8_11 = 10'h002;
  localparam logic [9:0] IDX_SEL_12_15 = 10'h003;
  localparam logic [9:0] IDX_MOD_EN = 10'h004;
  localparam logic [9:0] IDX_PIN_FLAG = 10'h005;
  localparam logic [9:0] IDX_MOD_FLAG = 10'h006;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h008;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h009;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int NUM_PINS = 8;
  localparam int NUM_MODULES = 8;
  localparam int FIELD_W = 2;
  localparam int IRQ_W = 2;
  localparam int IRQ_PIN_BIT = 0;
  localparam int IRQ_MOD_BIT = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Edge detect modes of a pin field
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_RISE = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_ANY = 2'h3;

  function automatic logic edge_hit(input logic [1:0] mode,
                                    input logic prev, input logic cur);
    logic hit;
    hit = 1'b0;
    case (mode)
      MODE_RISE: hit = cur & ~prev;
      MODE_FALL: hit = prev & ~cur;
      MODE_ANY: hit = cur ^ prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

/* File: wake_source_model.sv */
`timescale 1ns/1ns
module wake_source_model
(
  input wire logic clk,
  output logic [7:0] wake_pins,
  output logic [7:0] module_wake_flags
);
  // ----------------------------------------------------------------
  // Far side drivers
  // ----------------------------------------------------------------
  // Levels change just after an edge, so the block never samples them
  // while they are moving.
  initial
  begin
    wake_pins = 8'h00;
    module_wake_flags = 8'h00;
  end

  task automatic set_pins(input logic [7:0] v);
    @(posedge clk);
    wake_pins <= v;
  endtask

  // A module flag is held for one cycle only, the shortest pulse that
  // the block is promised to see.
  task automatic pulse_flags(input logic [7:0] v);
    @(posedge clk);
    module_wake_flags <= v;
    @(posedge clk);
    module_wake_flags <= 8'h00;
  endtask
endmodule
